// ===== adcseq_cfg.svh
// Constants of the converter sequencer: widths, reset values and timing counts
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH

// ==========================================================================
// Field widths
`define ADCSEQ_RAW_W        12
`define ADCSEQ_RES_W        16
`define ADCSEQ_ACC_W        20
`define ADCSEQ_PHASE_W      10
`define ADCSEQ_PRESCALER_FIELD_W      3
`define ADCSEQ_ACCN_W       3
`define ADCSEQ_SDLY_W       4
`define ADCSEQ_SLEN_W       8
`define ADCSEQ_IDLY_W       8
`define ADCSEQ_SCNT_W       8

// ==========================================================================
// Reset values
`define ADCSEQ_RESULT_RST   16'h0000
`define ADCSEQ_ACC_RST      20'h00000

// ==========================================================================
// Timing counts (converter clock phases are counted in half periods)
`define ADCSEQ_SAMPLE_BASE  10'h002
`define ADCSEQ_CONV_HALF    10'h01b
`define ADCSEQ_FORMAT_LAST  2'h1
`define ADCSEQ_TRUNC_LOG2   3'h4
`define ADCSEQ_BITS12       5'h0c
`define ADCSEQ_BITS10       5'h0a
`define ADCSEQ_RES_BITS     5'h10

`endif

// ===== adcseq_pkg.sv
// Types shared by the converter sequencer: configuration carrier and states
`include "adcseq_cfg.svh"

package adcseq_pkg;

	// ======================================================================
	// Conversion settings, sampled at each start
	typedef struct packed {
		logic                         free_run_bit;             // Restart after each result
		logic                         diff_mode;                // Signed differential result
		logic                         res_10bit;                // 10-bit instead of 12-bit
		logic                         left_adjust_bit;          // MSbs into high byte
		logic [`ADCSEQ_ACCN_W-1:0]    accumulation_count_field; // log2 of sample count
		logic [`ADCSEQ_PRESCALER_FIELD_W-1:0]   prescaler_field;          // Half period minus one
		logic [`ADCSEQ_SDLY_W-1:0]    sampling_delay_field;     // Extra sample cycles
		logic [`ADCSEQ_SLEN_W-1:0]    sample_length_field;      // Extra sample cycles
		logic [`ADCSEQ_IDLY_W-1:0]    initialization_delay_field; // Wait before sampling
	} adcseq_cfg_t;

	// ======================================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ADCSEQ_IDLE    = 3'h0,
		ADCSEQ_STARTUP = 3'h1,
		ADCSEQ_INIT    = 3'h2,
		ADCSEQ_SAMPLE  = 3'h3,
		ADCSEQ_CONVERT = 3'h4,
		ADCSEQ_FORMAT  = 3'h5
	} adcseq_state_t;

endpackage

// ===== adcseq_sequencer.sv
// Converter sequencer: triggers, prescaler, phase timing and result formatting
//
// Overview of operation
// R1: Start conversion one clock after trigger
// R2: Prescaler held reset while idle
// R3: Sample two then convert 13.5 converter cycles
// R4: Two clock cycles of result formatting
// R5: Store result and set ready flag
// R6: Accumulate counted samples, start bit held
// R7: One startup, then per-sample phases and formatting
// R8: Free-run restarts right after completion
// R9: Ready event and flag every conversion
// R10: Free-run repeats whole accumulated conversions
// R11: Software changes settings only outside free-run
// R12: Sampling lasts two plus delay plus length
// R13: Sample time includes delay and length
// R14: Initialization delay holds off sampling
// R15: Single-ended results unsigned, zero extended
// R16: Differential results sign-extended two's complement
// R17: Right adjust default, left adjust option
// R18: Start bit reads one while busy
// R19: Event rising edge starts conversion
// R20: Accumulator cleared at every start
// R21: Truncate sums beyond sixteen samples
// R22: Converter clock from restartable counter divider
`timescale 1ns/100ps
`include "adcseq_cfg.svh"

module adcseq_sequencer (
	input  wire logic                         core_clk_i,             // Peripheral clock
	input  wire logic                         reset_i,                // Sync reset, high
	input  wire adcseq_pkg::adcseq_cfg_t      config_i,               // Conversion settings
	input  wire logic                         start_write_i,          // Write of one to start
	input  wire logic                         event_enable_i,         // Event start enable
	input  wire logic                         event_i,                // Incoming event level
	input  wire logic                         flag_clear_i,           // Clear ready flag
	input  wire logic [`ADCSEQ_RAW_W-1:0]     core_data_i,            // Converter core output
	output logic                              adc_clk_o,              // Converter clock
	output logic                              sample_hold_o,          // Sample phase active
	output logic                              converting_o,           // Conversion phase
	output logic                              start_conversion_bit_o, // Busy readback
	output logic [`ADCSEQ_RES_W-1:0]          result_register_o,      // Formatted result
	output logic                              result_ready_flag_o,    // Sticky ready flag
	output logic                              result_ready_event_o    // One-cycle ready event
);

	// ======================================================================
	// Functions

	// Widen one raw sample to accumulator width, signed or not
	function automatic logic [`ADCSEQ_ACC_W-1:0] sample_ext(
		input logic [`ADCSEQ_RAW_W-1:0] d,
		input logic                     diff,
		input logic                     r10
	);
		logic [`ADCSEQ_ACC_W-1:0] v;
		v = `ADCSEQ_ACC_RST;
		if (r10) begin
			// 10-bit mode keeps the upper bits of the core word
			v = diff ? {{10{d[11]}}, d[11:2]} : {10'h000, d[11:2]}; // [R15] [R16]
		end else begin
			v = diff ? {{8{d[11]}}, d} : {8'h00, d}; // [R15] [R16]
		end
		return v;
	endfunction

	// Truncate and adjust the accumulated sum into the result word
	function automatic logic [`ADCSEQ_RES_W-1:0] finalize(
		input logic [`ADCSEQ_ACC_W-1:0] a,
		input adcseq_pkg::adcseq_cfg_t  c
	);
		logic [2:0]                 tr;
		logic [2:0]                 keep;
		logic [4:0]                 lsh;
		logic [`ADCSEQ_ACC_W-1:0]   s;
		logic [`ADCSEQ_RES_W-1:0]   r;
		tr   = (c.accumulation_count_field > `ADCSEQ_TRUNC_LOG2) ?
		       3'(c.accumulation_count_field - `ADCSEQ_TRUNC_LOG2) : 3'h0;
		keep = (c.accumulation_count_field > `ADCSEQ_TRUNC_LOG2) ?
		       `ADCSEQ_TRUNC_LOG2 : c.accumulation_count_field;
		// Arithmetic shift keeps the sign of differential sums
		s    = `ADCSEQ_ACC_W'($signed(a) >>> tr); // [R21]
		lsh  = 5'(`ADCSEQ_RES_BITS - (c.res_10bit ? `ADCSEQ_BITS10 : `ADCSEQ_BITS12)
		       - {2'h0, keep});
		r    = s[`ADCSEQ_RES_W-1:0];
		return c.left_adjust_bit ? `ADCSEQ_RES_W'(r << lsh) : r; // [R17]
	endfunction

	// Length of the current phase in converter half periods
	function automatic logic [`ADCSEQ_PHASE_W-1:0] phase_target(
		input adcseq_pkg::adcseq_state_t s,
		input adcseq_pkg::adcseq_cfg_t   c
	);
		logic [`ADCSEQ_PHASE_W-1:0] sum;
		logic [`ADCSEQ_PHASE_W-1:0] t;
		sum = `ADCSEQ_SAMPLE_BASE + {6'h00, c.sampling_delay_field}
		      + {2'h0, c.sample_length_field};
		case (s)
			adcseq_pkg::ADCSEQ_INIT: begin
				t = {1'b0, c.initialization_delay_field, 1'b0}; // [R14]
			end
			adcseq_pkg::ADCSEQ_SAMPLE: begin
				t = {sum[`ADCSEQ_PHASE_W-2:0], 1'b0}; // [R3] [R12] [R13]
			end
			adcseq_pkg::ADCSEQ_CONVERT: begin
				t = `ADCSEQ_CONV_HALF; // [R3]
			end
			default: begin
				t = 10'h001;
			end
		endcase
		return t;
	endfunction

	// ======================================================================
	// State

	adcseq_pkg::adcseq_state_t            state_r;       // Sequencer state
	adcseq_pkg::adcseq_state_t            state_nxt;     // Next state
	adcseq_pkg::adcseq_cfg_t              cfg_r;         // Settings of this run
	logic                                 evt_s1_r;      // Event sync stage one
	logic                                 evt_s2_r;      // Event sync stage two
	logic                                 evt_s3_r;      // Event edge history
	logic [`ADCSEQ_PRESCALER_FIELD_W-1:0]           div_cnt_r;     // Prescaler counter
	logic                                 adc_clk_r;     // Converter clock level
	logic [`ADCSEQ_PHASE_W-1:0]           phase_cnt_r;   // Half periods in phase
	logic [1:0]                           fmt_cnt_r;     // Formatting cycle
	logic [`ADCSEQ_SCNT_W-1:0]            samp_cnt_r;    // Samples taken so far
	logic [`ADCSEQ_ACC_W-1:0]             sample_r;      // Last widened sample
	logic [`ADCSEQ_ACC_W-1:0]             acc_r;         // Running sum
	logic [`ADCSEQ_RES_W-1:0]             result_r;      // Result word
	logic                                 flag_r;        // Ready flag
	logic                                 event_r;       // Ready event pulse
	logic                                 busy_r;        // Start bit readback
	logic                                 hold_r;        // Sample phase output
	logic                                 conv_r;        // Convert phase output

	// ======================================================================
	// Decoding

	wire                                  is_idle;       // Nothing in progress
	wire                                  evt_rise;      // Event rising edge
	wire                                  trigger;       // Accepted start
	wire                                  run_div;       // Prescaler released
	wire                                  half_tick;     // Converter half period
	wire [`ADCSEQ_PHASE_W-1:0]            target;        // Current phase length
	wire                                  phase_done;    // Phase finishes now
	wire                                  fmt_end;       // Last formatting cycle
	wire                                  last_sample;   // Final sample of burst
	wire                                  done;          // Conversion complete
	wire                                  restart;       // Free-run start
	wire                                  load_cfg;      // Capture settings

	assign is_idle     = (state_r == adcseq_pkg::ADCSEQ_IDLE);
	// Only the second and third stages are compared
	assign evt_rise    = evt_s2_r & ~evt_s3_r; // [R19]
	// Starts while busy are ignored; the start bit already reads one
	assign trigger     = is_idle & (start_write_i | (event_enable_i & evt_rise)); // [R1]
	assign run_div     = (state_r == adcseq_pkg::ADCSEQ_INIT) |
	                     (state_r == adcseq_pkg::ADCSEQ_SAMPLE) |
	                     (state_r == adcseq_pkg::ADCSEQ_CONVERT); // [R2]
	assign half_tick   = run_div & (div_cnt_r == cfg_r.prescaler_field); // [R22]
	assign target      = phase_target(state_r, cfg_r);
	assign phase_done  = half_tick & (phase_cnt_r == `ADCSEQ_PHASE_W'(target - 10'h001));
	assign fmt_end     = (state_r == adcseq_pkg::ADCSEQ_FORMAT) &
	                     (fmt_cnt_r == `ADCSEQ_FORMAT_LAST); // [R4]
	assign last_sample = (samp_cnt_r == `ADCSEQ_SCNT_W'((9'h001 <<
	                     cfg_r.accumulation_count_field) - 9'h001)); // [R6]
	assign done        = fmt_end & last_sample; // [R5]
	// Free-run reads the live bit so software can stop it mid-run
	assign restart     = done & config_i.free_run_bit; // [R8] [R10]
	assign load_cfg    = trigger | restart;

	// ======================================================================
	// Next state

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			adcseq_pkg::ADCSEQ_IDLE: begin
				if (trigger) begin
					state_nxt = adcseq_pkg::ADCSEQ_STARTUP; // [R1]
				end
			end
			adcseq_pkg::ADCSEQ_STARTUP: begin
				// One startup cycle per run, not per sample
				if (cfg_r.initialization_delay_field != 8'h00) begin
					state_nxt = adcseq_pkg::ADCSEQ_INIT; // [R14] [R7]
				end else begin
					state_nxt = adcseq_pkg::ADCSEQ_SAMPLE;
				end
			end
			adcseq_pkg::ADCSEQ_INIT: begin
				if (phase_done) begin
					state_nxt = adcseq_pkg::ADCSEQ_SAMPLE; // [R14]
				end
			end
			adcseq_pkg::ADCSEQ_SAMPLE: begin
				if (phase_done) begin
					state_nxt = adcseq_pkg::ADCSEQ_CONVERT; // [R3]
				end
			end
			adcseq_pkg::ADCSEQ_CONVERT: begin
				if (phase_done) begin
					state_nxt = adcseq_pkg::ADCSEQ_FORMAT; // [R4]
				end
			end
			adcseq_pkg::ADCSEQ_FORMAT: begin
				if (fmt_end) begin
					if (!last_sample) begin
						state_nxt = adcseq_pkg::ADCSEQ_SAMPLE; // [R6] [R7]
					end else if (restart) begin
						state_nxt = adcseq_pkg::ADCSEQ_STARTUP; // [R8] [R10]
					end else begin
						state_nxt = adcseq_pkg::ADCSEQ_IDLE;
					end
				end
			end
			default: begin
				state_nxt = adcseq_pkg::ADCSEQ_IDLE;
			end
		endcase
	end

	// ======================================================================
	// Sequencer registers

	// State, settings capture and phase outputs
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_r <= adcseq_pkg::ADCSEQ_IDLE;
			cfg_r   <= '0;
			busy_r  <= 1'b0;
			hold_r  <= 1'b0;
			conv_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (load_cfg) begin
				cfg_r <= config_i;
			end
			// Start bit stays one across a whole burst and free-run
			busy_r  <= (state_nxt != adcseq_pkg::ADCSEQ_IDLE); // [R18] [R6]
			hold_r  <= (state_nxt == adcseq_pkg::ADCSEQ_SAMPLE);
			conv_r  <= (state_nxt == adcseq_pkg::ADCSEQ_CONVERT);
		end
	end

	// Event synchroniser and edge history
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			evt_s1_r <= 1'b0;
			evt_s2_r <= 1'b0;
			evt_s3_r <= 1'b0;
		end else begin
			evt_s1_r <= event_i;
			evt_s2_r <= evt_s1_r;
			evt_s3_r <= evt_s2_r;
		end
	end

	// Prescaler: held cleared outside converter phases
	always_ff @(posedge core_clk_i) begin
		if (reset_i || !run_div) begin
			div_cnt_r <= 3'h0; // [R2]
			adc_clk_r <= 1'b0;
		end else if (half_tick) begin
			div_cnt_r <= 3'h0; // [R22]
			adc_clk_r <= ~adc_clk_r;
		end else begin
			div_cnt_r <= 3'(div_cnt_r + 3'h1);
		end
	end

	// Phase and formatting counters
	always_ff @(posedge core_clk_i) begin
		if (reset_i || (state_nxt != state_r)) begin
			phase_cnt_r <= 10'h000;
			fmt_cnt_r   <= 2'h0;
		end else begin
			if (half_tick) begin
				phase_cnt_r <= `ADCSEQ_PHASE_W'(phase_cnt_r + 10'h001);
			end
			if (state_r == adcseq_pkg::ADCSEQ_FORMAT) begin
				fmt_cnt_r <= 2'(fmt_cnt_r + 2'h1);
			end
		end
	end

	// Sample capture, accumulation and sample count
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sample_r   <= `ADCSEQ_ACC_RST;
			acc_r      <= `ADCSEQ_ACC_RST;
			samp_cnt_r <= 8'h00;
		end else if (state_r == adcseq_pkg::ADCSEQ_STARTUP) begin
			acc_r      <= `ADCSEQ_ACC_RST; // [R20]
			samp_cnt_r <= 8'h00;
		end else begin
			if ((state_r == adcseq_pkg::ADCSEQ_CONVERT) && phase_done) begin
				sample_r <= sample_ext(core_data_i, cfg_r.diff_mode, cfg_r.res_10bit);
			end
			// First formatting cycle adds the sample in
			if ((state_r == adcseq_pkg::ADCSEQ_FORMAT) && (fmt_cnt_r == 2'h0)) begin
				acc_r <= `ADCSEQ_ACC_W'(acc_r + sample_r); // [R6]
			end
			if (fmt_end && !last_sample) begin
				samp_cnt_r <= 8'(samp_cnt_r + 8'h01);
			end
		end
	end

	// Result, sticky flag and event pulse
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			result_r <= `ADCSEQ_RESULT_RST;
			flag_r   <= 1'b0;
			event_r  <= 1'b0;
		end else begin
			if (done) begin
				result_r <= finalize(acc_r, cfg_r); // [R5] [R17]
			end
			// A completion in the clear cycle keeps the flag set
			flag_r  <= done | (flag_r & ~flag_clear_i); // [R5] [R9]
			event_r <= done; // [R9]
		end
	end

	// ======================================================================
	// Outputs

	assign adc_clk_o              = adc_clk_r;
	assign sample_hold_o          = hold_r;
	assign converting_o           = conv_r;
	assign start_conversion_bit_o = busy_r;
	assign result_register_o      = result_r;
	assign result_ready_flag_o    = flag_r;
	assign result_ready_event_o   = event_r;

endmodule

// ===== adcseq_monitor.sv
// Port timing checker of the converter sequencer, bound into the design
`timescale 1ns/100ps
`include "adcseq_cfg.svh"

module adcseq_monitor (
	input wire logic                     core_clk_i,             // Clock
	input wire logic                     reset_i,                // Reset
	input wire adcseq_pkg::adcseq_cfg_t  config_i,               // Settings
	input wire logic                     start_write_i,          // Start write
	input wire logic                     adc_clk_o,              // Converter clock
	input wire logic                     sample_hold_o,          // Sampling
	input wire logic                     converting_o,           // Converting
	input wire logic                     start_conversion_bit_o, // Busy
	input wire logic [`ADCSEQ_RES_W-1:0] result_register_o,      // Result
	input wire logic                     result_ready_flag_o,    // Flag
	input wire logic                     result_ready_event_o    // Event
);
	// ==================================================================
	// Phase length counters
	logic [15:0] samp_cnt_r; // Cycles spent sampling
	logic [15:0] conv_cnt_r; // Cycles spent converting
	logic [15:0] samp_exp;   // Expected sampling span
	logic [15:0] conv_exp;   // Expected conversion span
	// Spans in clocks; the span settings are held steady while a run is busy
	assign samp_exp = 16'((2 + config_i.sampling_delay_field + config_i.sample_length_field)
		* 2 * (config_i.prescaler_field + 1));
	assign conv_exp = 16'(27 * (config_i.prescaler_field + 1));
	// Count while high, clear while low, so the count is seen at the fall
	always_ff @(posedge core_clk_i) begin
		samp_cnt_r <= (reset_i || !sample_hold_o) ? 16'h0000 : samp_cnt_r + 16'h0001;
		conv_cnt_r <= (reset_i || !converting_o) ? 16'h0000 : conv_cnt_r + 16'h0001;
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	a_start_next_cycle: assert property (start_write_i && !start_conversion_bit_o |=>
		start_conversion_bit_o) else $error("start not taken");
	a_clk_idle_low: assert property (!start_conversion_bit_o |-> !adc_clk_o)
		else $error("converter clock runs while idle");
	a_samp_span: assert property ($fell(sample_hold_o) |-> samp_cnt_r == samp_exp)
		else $error("sampling span wrong");
	a_conv_span: assert property ($fell(converting_o) |-> conv_cnt_r == conv_exp)
		else $error("conversion span wrong");
	a_conv_after_samp: assert property ($rose(converting_o) |-> $past(sample_hold_o) &&
		!sample_hold_o) else $error("conversion not after sampling");
	a_format_two: assert property ($rose(result_ready_event_o) |->
		$past(converting_o, 3) && !$past(converting_o, 2)) else $error("format span wrong");
	a_flag_with_event: assert property (result_ready_event_o |-> result_ready_flag_o)
		else $error("flag missing at result");
	a_event_single: assert property (result_ready_event_o |=> !result_ready_event_o)
		else $error("event longer than one cycle");
	a_busy_until_done: assert property ($fell(start_conversion_bit_o) |->
		result_ready_event_o) else $error("busy fell early");
	a_result_holds: assert property (!result_ready_event_o |-> $stable(result_register_o))
		else $error("result moved without completion");
	a_free_run_on: assert property (result_ready_event_o && config_i.free_run_bit |->
		start_conversion_bit_o) else $error("free run stopped");
	a_phase_busy: assert property (sample_hold_o || converting_o |->
		start_conversion_bit_o) else $error("phase while not busy");
	// Main scenarios reached
	c_free_run: cover property (result_ready_event_o && config_i.free_run_bit);
	c_accum: cover property (result_ready_event_o && config_i.accumulation_count_field != 0);
	c_left: cover property (result_ready_event_o && config_i.left_adjust_bit);
endmodule

bind adcseq_sequencer adcseq_monitor u_mon (
	.core_clk_i, .reset_i, .config_i, .start_write_i, .adc_clk_o, .sample_hold_o,
	.converting_o, .start_conversion_bit_o, .result_register_o, .result_ready_flag_o,
	.result_ready_event_o
);

// ===== adcseq_core_model.sv
// Behavioural converter core: holds the sampled word through conversion
`timescale 1ns/100ps
`include "adcseq_cfg.svh"

module adcseq_core_model (
	input  wire logic                     core_clk_i,    // Clock
	input  wire logic                     sample_hold_i, // Sampling phase
	input  wire logic                     converting_i,  // Conversion phase
	input  wire logic [`ADCSEQ_RAW_W-1:0] analog_i,      // Input level as code
	output logic      [`ADCSEQ_RAW_W-1:0] core_data_o    // Converted word
);
	logic [`ADCSEQ_RAW_W-1:0] held_r; // Word captured while sampling
	// Track the input only while the hold switch is closed
	always_ff @(posedge core_clk_i) begin
		if (sample_hold_i) begin
			held_r <= analog_i;
		end
	end
	// Word is invalid outside conversion, so show its inverse there
	assign core_data_o = converting_i ? held_r : ~held_r;
endmodule

// ===== adc_conversion_sequencer_tb_top.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/100ps
`include "adcseq_cfg.svh"

module adc_conversion_sequencer_tb_top;
	`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
	// ==================================================================
	// Signals
	logic                    clk;     // Peripheral clock
	logic                    rst;     // Sync reset
	adcseq_pkg::adcseq_cfg_t cfg;     // Settings
	logic                    start_w; // Start write
	logic                    ev_en;   // Event enable
	logic                    ev;      // Event level
	logic                    fclr;    // Flag clear
	logic [11:0]             analog;  // Model input
	logic [11:0]             cdata;   // Core word
	logic                    aclk;    // Converter clock
	logic                    smp;     // Sampling
	logic                    cnv;     // Converting
	logic                    busy;    // Start bit
	logic [15:0]             res;     // Result
	logic                    flag;    // Ready flag
	logic                    rdy;     // Ready event
	int                      n_fail = 0;
	int                      total_checks = 0;
	int                      cyc;     // Cycles from take to result

	adcseq_sequencer uut (.core_clk_i(clk), .reset_i(rst), .config_i(cfg),
		.start_write_i(start_w), .event_enable_i(ev_en), .event_i(ev), .flag_clear_i(fclr),
		.core_data_i(cdata), .adc_clk_o(aclk), .sample_hold_o(smp), .converting_o(cnv),
		.start_conversion_bit_o(busy), .result_register_o(res), .result_ready_flag_o(flag),
		.result_ready_event_o(rdy));
	adcseq_core_model core (.core_clk_i(clk), .sample_hold_i(smp), .converting_i(cnv),
		.analog_i(analog), .core_data_o(cdata));

	// ==================================================================
	// Shared tasks
	// Wait for the ready event, bounded so a stuck run cannot hang here
	task automatic wait_ev();
		while (!rdy && cyc < 3000) begin
			@(negedge clk);
			cyc++;
		end
	endtask
	// One run; the event path adds two or three sync edges of latency
	task automatic go(input logic [11:0] d, input int exp, input logic [15:0] r, input bit e);
		analog = d;
		ev_en = e;
		ev = e;
		start_w = !e;
		@(negedge clk);
		start_w = 1'b0;
		ev = 1'b0;
		cyc = 1;
		wait_ev();
		`CHK(cyc >= exp + 2 * e && cyc <= exp + 3 * e, 1'b1)
		`CHK(res, r)
		`CHK(flag, 1'b1)
		`CHK(busy, cfg.free_run_bit)
		fclr = 1'b1;
		@(negedge clk);
		fclr = 1'b0;
		`CHK(flag, 1'b0)
	endtask

	// ==================================================================
	// Scenarios
	task automatic t_single();
		cfg = '0;
		go(12'hfff, 35, 16'h0fff, 0);
		go(12'h3a5, 35, 16'h03a5, 0);
		$display("single done");
	endtask
	task automatic t_format();
		cfg = '0;
		cfg.left_adjust_bit = 1'b1;
		go(12'habc, 35, 16'habc0, 0);
		cfg = '0;
		cfg.diff_mode = 1'b1;
		go(12'h800, 35, 16'hf800, 0);
		go(12'h7ff, 35, 16'h07ff, 0);
		cfg.res_10bit = 1'b1;
		go(12'h800, 35, 16'hfe00, 0);
		cfg.diff_mode = 1'b0;
		go(12'hffc, 35, 16'h03ff, 0);
		$display("format done");
	endtask
	task automatic t_timing();
		cfg = '0;
		cfg.prescaler_field = 3'h1;
		cfg.sampling_delay_field = 4'h1;
		cfg.sample_length_field = 8'h02;
		cfg.initialization_delay_field = 8'h03;
		go(12'h456, 90, 16'h0456, 0);
		cfg = '0;
		go(12'h123, 35, 16'h0123, 1);
		// Event edge with the enable low must not start a run
		ev_en = 1'b0;
		ev = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(busy, 1'b0)
		ev = 1'b0;
		@(negedge clk);
		$display("timing done");
	endtask
	task automatic t_accum();
		cfg = '0;
		cfg.accumulation_count_field = 3'h1;
		go(12'h100, 68, 16'h0200, 0);
		go(12'h100, 68, 16'h0200, 0);
		cfg.left_adjust_bit = 1'b1;
		go(12'h100, 68, 16'h1000, 0);
		cfg.left_adjust_bit = 1'b0;
		cfg.accumulation_count_field = 3'h5;
		go(12'hfff, 1058, 16'hfff0, 0);
		$display("accum done");
	endtask
	// Free run with bursts; the flag was cleared between the first two results
	task automatic t_free();
		cfg = '0;
		cfg.free_run_bit = 1'b1;
		cfg.accumulation_count_field = 3'h1;
		go(12'h010, 68, 16'h0020, 0);
		analog = 12'h020;
		cyc = 1;
		wait_ev();
		`CHK(cyc, 67)
		`CHK(res, 16'h0040)
		`CHK(flag, 1'b1)
		@(negedge clk);
		// Stop free run, then let the run already restarted finish
		cfg.free_run_bit = 1'b0;
		// Restart edge was before the previous negedge, so it is not counted
		cyc = 1;
		wait_ev();
		`CHK(cyc, 67)
		`CHK(busy, 1'b0)
		$display("free done");
	endtask

	// ==================================================================
	// Verdict and run control
	task automatic conclude();
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is about 1,900 cycles; this allows about five times that
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		cfg = '0;
		start_w = 1'b0;
		ev_en = 1'b0;
		ev = 1'b0;
		fclr = 1'b0;
		analog = 12'h000;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_single();
		t_format();
		t_timing();
		t_accum();
		t_free();
		conclude();
	end
endmodule
